//--- rtl/wdog_consts.vh
// constants of the windowed watchdog timer
// Function
// - 12-bit down counter loaded from load value
// - counter ticks at slow clock divided by 128
// - load value resets to 0xfff, running
// - fault reset enable resets to one
// - mode register writable once per reset
// - mode write reloads counter and restarts
// - keyed restart in window reloads counter and prescaler
// - control writes with wrong key ignored
// - underflow sets flag, fault if enabled
// - early restart sets error, fault, even disabled
// - window at or above load means no error
// - interrupt on flag when irq enabled
// - fault reset raises a reset request, keeps flags
// - status read or reset clears flags, fault
// - counter halts in debug or idle if set
// - processor reset restores initial configuration
// - fault reset selects system or processor
// - processor only select picks reset kind
// - disable bit stops the counter
`ifndef WDOG_CONSTS_VH
`define WDOG_CONSTS_VH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define WD_CTRL_OFS 12'h000
`define WD_MODE_OFS 12'h004
`define WD_STAT_OFS 12'h008
// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define WD_KEY_MSB 31
`define WD_KEY_LSB 24
`define WD_KEY_VAL 8'ha5
`define WD_RESTART_BIT 0
// ----------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------
`define WD_LOAD_MSB 11
`define WD_LOAD_LSB 0
`define WD_FIRQ_BIT 12
`define WD_FRST_BIT 13
`define WD_PROC_BIT 14
`define WD_DIS_BIT 15
`define WD_DELTA_MSB 27
`define WD_DELTA_LSB 16
`define WD_DBGH_BIT 28
`define WD_IDLEH_BIT 29
`define WD_MODE_RST 32'h3fff2fff
// ----------------------------------------------------------------
// status fields and timing
// ----------------------------------------------------------------
`define WD_UNF_BIT 0
`define WD_ERR_BIT 1
`define WD_PRESCALE 8'h80
`define WD_PRESCALE_W 7
`endif

//--- rtl/wdog_prescaler.v
// divide-by-128 tick generator on the synchronised slow clock
`timescale 1ns/1ns
module wdog_prescaler (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire slow_rise,
  input wire restart,
  // tick out
  output reg tick
);
`include "wdog_consts.vh"
  reg [`WD_PRESCALE_W-1:0] div_q;

  // count slow clock rising edges, pulse tick on the 128th
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= {`WD_PRESCALE_W{1'b0}};
      tick <= 1'b0;
    end else if (restart) begin
      div_q <= {`WD_PRESCALE_W{1'b0}};
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (slow_rise) begin
        div_q <= div_q + 1'b1;
        tick <= &div_q;
      end
    end
  end
endmodule // wdog_prescaler

//--- rtl/wdog_top.v
// windowed watchdog timer with apb register access
`timescale 1ns/1ns
module wdog_top (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // system inputs
  input wire slow_clk,
  input wire debug_state,
  input wire idle_state,
  // outputs
  output reg fault_irq,
  output reg fault_out,
  output reg proc_reset_req,
  output reg sys_reset_req,
  output reg [11:0] counter_value
);
`include "wdog_consts.vh"
  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  reg [2:0] sclk_q;
  reg dbg_m_q, dbg_q, idle_m_q, idle_q;

  // two flops for each pin, one more for edge detect on slow clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 3'h0;
      dbg_m_q <= 1'b0;
      dbg_q <= 1'b0;
      idle_m_q <= 1'b0;
      idle_q <= 1'b0;
    end else begin
      sclk_q <= {sclk_q[1:0], slow_clk};
      dbg_m_q <= debug_state;
      dbg_q <= dbg_m_q;
      idle_m_q <= idle_state;
      idle_q <= idle_m_q;
    end
  end

  wire slow_rise = sclk_q[1] & ~sclk_q[2];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire acc = psel & penable & pready;
  wire wr_ctrl = acc & pwrite & (paddr == `WD_CTRL_OFS);
  wire wr_mode = acc & pwrite & (paddr == `WD_MODE_OFS);
  wire rd_stat = acc & ~pwrite & (paddr == `WD_STAT_OFS);
  wire mapped = (paddr == `WD_CTRL_OFS) | (paddr == `WD_MODE_OFS) |
    (paddr == `WD_STAT_OFS);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [31:0] mode_q;
  reg mode_locked_q;
  reg [11:0] cnt_q;
  reg unf_q, err_q;
  wire tick;

  wire [11:0] load_value = mode_q[`WD_LOAD_MSB:`WD_LOAD_LSB];
  wire [11:0] delta_window = mode_q[`WD_DELTA_MSB:`WD_DELTA_LSB];
  wire fault_irq_enable = mode_q[`WD_FIRQ_BIT];
  wire fault_reset_enable = mode_q[`WD_FRST_BIT];
  wire proc_only_reset = mode_q[`WD_PROC_BIT];
  wire disable_bit = mode_q[`WD_DIS_BIT];
  wire debug_halt = mode_q[`WD_DBGH_BIT];
  wire idle_halt = mode_q[`WD_IDLEH_BIT];

  // keyed restart command
  wire key_ok = (pwdata[`WD_KEY_MSB:`WD_KEY_LSB] == `WD_KEY_VAL);
  wire restart_cmd = wr_ctrl & key_ok & pwdata[`WD_RESTART_BIT];
  // accepted mode write, only the first since reset
  wire mode_take = wr_mode & ~mode_locked_q;
  // restart outside the window: counter above the delta value
  wire early = restart_cmd & (cnt_q > delta_window);
  wire good_restart = restart_cmd & ~early;

  // halt conditions
  wire halted = disable_bit | (debug_halt & dbg_q) | (idle_halt & idle_q);
  wire underflow = tick & ~halted & (cnt_q == 12'h000);

  // prescaler restarts with an in-window restart or a mode write reload
  wdog_prescaler u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .slow_rise(slow_rise),
    .restart(good_restart | mode_take),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // mode register, write once
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `WD_MODE_RST;
      mode_locked_q <= 1'b0;
    end else if (mode_take) begin
      mode_q <= pwdata & 32'h3fffffff;
      mode_locked_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // down counter
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 12'hfff;
    end else if (mode_take) begin
      cnt_q <= pwdata[`WD_LOAD_MSB:`WD_LOAD_LSB];
    end else if (good_restart) begin
      cnt_q <= load_value;
    end else if (underflow) begin
      cnt_q <= load_value;
    end else if (tick & ~halted) begin
      cnt_q <= cnt_q - 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // status flags, set wins over read clear
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unf_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      unf_q <= underflow | (unf_q & ~rd_stat);
      err_q <= early | (err_q & ~rd_stat);
    end
  end

  // ----------------------------------------------------------------
  // interrupt, fault and reset requests
  // ----------------------------------------------------------------
  wire unf_d = underflow | (unf_q & ~rd_stat);
  wire err_d = early | (err_q & ~rd_stat);
  wire fault_d = (unf_d & fault_reset_enable) | err_d;
  wire frst_d = (unf_d | err_d) & fault_reset_enable;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_irq <= 1'b0;
      fault_out <= 1'b0;
      proc_reset_req <= 1'b0;
      sys_reset_req <= 1'b0;
      counter_value <= 12'hfff;
    end else begin
      fault_irq <= (unf_d | err_d) & fault_irq_enable;
      fault_out <= fault_d;
      proc_reset_req <= frst_d & proc_only_reset;
      sys_reset_req <= frst_d & ~proc_only_reset;
      counter_value <= cnt_q;
    end
  end

  // ----------------------------------------------------------------
  // apb response: one wait state, read data at access
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel & penable & ~pready) begin
      pready <= 1'b1;
      pslverr <= ~mapped;
      // read data only moves on a read, so it holds across writes
      if (~pwrite) begin
        if (paddr == `WD_MODE_OFS)
          prdata <= mode_q;
        else if (paddr == `WD_STAT_OFS)
          prdata <= {30'h00000000, err_q, unf_q};
        else
          prdata <= 32'h00000000;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule // wdog_top

//--- verification/wdog_chk_properties.sv
// port checker for the windowed watchdog
`timescale 1ns/1ns
module wdog_chk (
  // apb side
  input wire pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  // watchdog outputs
  input wire fault_irq, fault_out, proc_reset_req, sys_reset_req,
  input wire [11:0] counter_value
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed access phase
  wire acc = psel && penable && pready;
  // ------------------------------
  // properties
  // ------------------------------
  a_one_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_map: assert property (acc |-> pslverr ==
    (paddr != 12'h000 && paddr != 12'h004 && paddr != 12'h008)) else $error("pslverr wrong");
  a_rdata_hold: assert property ($changed(prdata) |-> $past(psel && penable && !pwrite))
    else $error("prdata moved");
  a_req_excl: assert property (!(proc_reset_req && sys_reset_req))
    else $error("both resets");
  a_req_fault: assert property (proc_reset_req || sys_reset_req |-> fault_out)
    else $error("reset without fault");
  a_tick_gap: assert property (counter_value + 12'h001 == $past(counter_value) |=>
    (counter_value + 12'h001 != $past(counter_value))[*8]) else $error("tick too soon");
  a_stat_clear: assert property (acc && !pwrite && paddr == 12'h008 |-> ##2 !fault_irq)
    else $error("flags kept");
  cover property (acc && pslverr);
  cover property ($rose(sys_reset_req));
  cover property ($rose(proc_reset_req));
endmodule // wdog_chk
bind wdog_top wdog_chk u_chk (.*);

//--- verification/wdog_far_end.sv
// slow clock source and reset controller model
`timescale 1ns/1ns
module wdog_far_end (
  // clock and fault requests
  input wire pclk,
  input wire proc_reset_req,
  input wire sys_reset_req,
  // slow clock and reset tallies
  output reg slow_clk = 1'b0,
  output reg [7:0] proc_cnt_q = 8'h00,
  output reg [7:0] sys_cnt_q = 8'h00
);
  reg [2:0] div_q = 3'h0;
  reg proc_q = 1'b0;
  reg sys_q = 1'b0;
  // free running slow clock of ten pclk periods, reset requests counted on rise
  always @(posedge pclk) begin
    div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
    if (div_q == 3'h4) slow_clk <= !slow_clk;
    proc_q <= proc_reset_req;
    sys_q <= sys_reset_req;
    if (proc_reset_req && !proc_q) proc_cnt_q <= proc_cnt_q + 8'h01;
    if (sys_reset_req && !sys_q) sys_cnt_q <= sys_cnt_q + 8'h01;
  end
endmodule // wdog_far_end

//--- verification/windowed_watchdog_timer_tb_top.sv
// self-checking bench for the windowed watchdog
`timescale 1ns/1ns
`include "wdog_consts.vh"
module windowed_watchdog_timer_tb_top;
  reg pclk, presetn, psel, penable, pwrite, debug_state, idle_state, err;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, slow_clk, fault_irq, fault_out, proc_reset_req, sys_reset_req;
  wire [11:0] counter_value;
  wire [7:0] proc_cnt_q, sys_cnt_q;
  integer n_errors, tests_run, i, w;
  wdog_top u_dut (.*);
  wdog_far_end u_far (.*);
  // ------------------------------
  // clock and tasks
  // ------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task chk(input [63:0] name, input [31:0] exp, input [31:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        $display("ERROR %0s expected %h seen %h", name, exp, got);
        n_errors = n_errors + 1;
      end
    end
  endtask
  // one apb transfer, held until pready
  task apb(input wr, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      @(negedge pclk);
      while (i < 20 && pready !== 1'b1) begin
        i = i + 1;
        @(negedge pclk);
      end
      rd = prdata;
      err = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) chk("pready", 1, 0);
    end
  endtask
  task wait_cnt(input [11:0] v);
    for (w = 0; w < 9000 && counter_value !== v; w = w + 1)
      @(posedge pclk);
  endtask
  task do_reset;
    begin
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
    end
  endtask
  task test_done;
    begin
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // defaults after reset, unmapped access, key and tick timing
  task t_basic;
    begin
      apb(0, `WD_MODE_OFS, 0);
      chk("mode", 32'h3fff2fff, rd);
      chk("count", 32'hfff, counter_value);
      apb(0, 12'h00c, 0);
      chk("slverr", 1, {rd, err}); // unmapped reads zero
      wait_cnt(12'hffe);
      apb(1, `WD_CTRL_OFS, 32'h5a000001);
      repeat (3) @(posedge pclk);
      chk("badkey", 32'hffe, counter_value);
      apb(1, `WD_CTRL_OFS, {`WD_KEY_VAL, 24'h000001});
      repeat (3) @(posedge pclk);
      chk("restart", 32'h1ffe, {counter_value, fault_out});
      wait_cnt(12'hffe);
      chk("tick", 1, w > 1240 && w < 1320);
    end
  endtask
  // early restart, write once, status clear, underflow
  task t_window;
    begin
      apb(1, `WD_MODE_OFS, 32'h00017003);
      repeat (3) @(posedge pclk);
      chk("reload", 32'h3, counter_value);
      apb(1, `WD_CTRL_OFS, 32'ha5000001);
      repeat (3) @(posedge pclk);
      chk("early", 32'h3e, {counter_value, fault_out, fault_irq, proc_reset_req, sys_reset_req});
      chk("tally", 1, proc_cnt_q);
      apb(1, `WD_MODE_OFS, 32'h0000000f);
      apb(0, `WD_MODE_OFS, 0);
      chk("once", 32'h00017003, rd);
      apb(0, `WD_STAT_OFS, 0);
      chk("status", 32'h2, rd);
      repeat (3) @(posedge pclk);
      chk("clear", 0, {fault_out, fault_irq, proc_reset_req});
      for (w = 0; w < 8000 && fault_out !== 1'b1; w = w + 1)
        @(posedge pclk);
      repeat (3) @(posedge pclk);
      chk("unf", 32'h7, {counter_value, fault_out});
      apb(0, `WD_STAT_OFS, 0);
      chk("unfflag", 32'h1, rd);
    end
  endtask
  // processor reset restores mode, debug halt, system reset select
  task t_halt;
    begin
      do_reset;
      apb(0, `WD_MODE_OFS, 0);
      chk("modersv", 32'h3fff2fff, rd);
      debug_state <= 1'b1;
      apb(1, `WD_MODE_OFS, 32'h10002005);
      repeat (1400) @(posedge pclk);
      chk("halted", 32'h5, counter_value);
      apb(1, `WD_CTRL_OFS, 32'ha5000001);
      repeat (3) @(posedge pclk);
      chk("sysreq", 32'h15, {counter_value, proc_reset_req, sys_reset_req});
    end
  endtask
  // disable bit and idle halt, each after its own reset
  task t_idle;
    begin
      debug_state <= 1'b0;
      do_reset;
      apb(1, `WD_MODE_OFS, 32'h00008004);
      repeat (1400) @(posedge pclk);
      chk("disabled", 32'h4, counter_value);
      do_reset;
      idle_state <= 1'b1;
      apb(1, `WD_MODE_OFS, 32'h20000004);
      repeat (1400) @(posedge pclk);
      chk("idlehalt", 32'h4, counter_value);
      idle_state <= 1'b0;
      wait_cnt(12'h003);
      chk("resume", 1, w < 1400);
    end
  endtask
  // main sequence and watchdog
  initial begin
    n_errors = 0;
    tests_run = 0;
    {presetn, psel, penable, pwrite, debug_state, idle_state} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    do_reset;
    t_basic;
    t_window;
    t_halt;
    t_idle;
    test_done;
  end
  initial begin
    repeat (30000) @(posedge pclk);
    n_errors = n_errors + 1;
    test_done;
  end
endmodule // windowed_watchdog_timer_tb_top
